// >>> design/crf_pkg.sv
// constants, enumerations and carriers of the cpu register file
// assumes one 50 MHz bus clock and an AXI4-Lite master for debug access
package crf_pkg;
  // ----------------------------------------------------------------
  // register map and bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_INDEX = 8'h04;
  localparam logic [7:0] OFF_STACK = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // reset values, vectors and flag positions
  // ----------------------------------------------------------------
  localparam logic [7:0] INDEX_HIGH_RST = 8'h00;
  localparam logic [15:0] STACK_RST = 16'h00FF;
  localparam logic [7:0] STACK_LOW_FILL = 8'hFF;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RST = 8'h68;
  localparam int STAT_RUN = 0;
  localparam int STAT_INHIBIT = 1;
  // ----------------------------------------------------------------
  // operations and states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE, OP_FETCH, OP_JUMP, OP_BRANCH, OP_LOAD_A, OP_LOAD_X, OP_LOAD_HX,
    OP_STORE_A, OP_STORE_HX, OP_ADD, OP_SUB, OP_DECIMAL_ADJUST, OP_X_UNARY, OP_BIT_TEST,
    OP_ADD_TO_STACK_IMMEDIATE, OP_RESET_STACK_LOW, OP_PUSH, OP_PULL,
    OP_CLEAR_MASK_INSTR, OP_SEI, OP_TAP, OP_INT_ENTRY,
    OP_HX_INC
  } crf_opk_t;
  typedef enum logic [3:0] {
    UN_CLR, UN_INC, UN_DEC, UN_COM, UN_NEG, UN_LSL, UN_LSR, UN_ASR, UN_ROL, UN_ROR
  } crf_unop_t;
  typedef enum logic [3:0] {
    CND_ALWAYS, CND_EQ, CND_NE, CND_CC, CND_CS,
    CND_GREATER, CND_GREATER_EQUAL, CND_LESS_EQUAL, CND_LESS
  } crf_cond_t;
  typedef enum logic [1:0] {PH_VEC_HI, PH_VEC_GAP, PH_VEC_LO, PH_RUN} crf_phase_t;
  typedef struct packed {
    crf_opk_t kind;
    crf_unop_t unop;
    crf_cond_t cond;
    logic with_carry;
    logic [2:0] bitsel;
    logic [7:0] data8;
    logic [15:0] data16;
  } crf_op_t;
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } crf_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crf_axi_rsp_t;
endpackage : crf_pkg

// >>> design/crf_regs.sv
// programmer-visible cpu registers, flag logic and reset vector load
// assumes the sequencer issues one operation per cycle at most and that
// vector memory answers one cycle after an address is presented
// How it works
// [RULE1] reset leaves the accumulator untouched
// [RULE2] reset forces index high byte to zero
// [RULE3] reset leaves index low byte untouched
// [RULE4] reset loads stack pointer with 0x00FF
// [RULE5] program counter loaded from vector 0xFFFE/0xFFFF
// [RULE6] fetch increments counter; flow changes load it
// [RULE7] indexed base is full pair; some ops low
// [RULE8] index low works as general 8-bit register
// [RULE9] stack pointer marks next free stack slot
// [RULE10] stack add sign-extends its 8-bit immediate
// [RULE11] stack reset instruction touches low byte only
// [RULE12] flag bits 6 and 5 always one
// [RULE13] overflow flag on signed overflow; signed branches
// [RULE14] half carry from bit 3 on adds
// [RULE15] decimal adjust corrects using half carry, carry
// [RULE16] mask blocks interrupts; set on interrupt entry
// [RULE17] no interrupt right after mask clearing instruction
// [RULE18] negative flag follows result top bit
// [RULE19] zero flag when result all zeros
// [RULE20] carry on add carry, subtract borrow, shifts
// [RULE21] mask set by reset
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
module crf_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // operation from the sequencer
  input wire crf_pkg::crf_op_t op,
  input wire logic insn_boundary,
  input wire logic irq_request,
  // vector memory
  input wire logic [7:0] vec_data,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  // register views
  output logic cpu_ready,
  output logic [7:0] accumulator,
  output logic [15:0] index_pair,
  output logic [15:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic irq_take,
  // axi4-lite slave
  input wire crf_pkg::crf_axi_req_t axi_req,
  output crf_pkg::crf_axi_rsp_t axi_rsp
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] ix_h;
    logic [7:0] ix_l;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] flags;
    logic inhibit;
    logic irq_take;
    crf_phase_t phase;
    logic run;
    logic [7:0] vec_hi;
    logic [15:0] vec_addr;
    logic vec_rd;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    crf_axi_rsp_t rsp;
  } crf_state_t;

  crf_state_t st_reg;
  crf_state_t st_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] crf_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : crf_merge

  // returns {overflow, carry, result}
  function automatic logic [9:0] crf_unary(input crf_unop_t u, input logic [7:0] x,
                                           input logic c_in);
    logic [7:0] r;
    logic c;
    logic v;
    r = x;
    c = c_in;
    v = 1'b0;
    unique case (u)
      UN_CLR: r = 8'h00;
      UN_INC: r = x + 8'h01;
      UN_DEC: r = x - 8'h01;
      UN_COM: {c, r} = {1'b1, ~x};
      UN_NEG: {c, r} = {(x != 8'h00), 8'h00 - x};
      UN_LSL: {c, r} = {x, 1'b0};
      UN_LSR: {r, c} = {1'b0, x};
      UN_ASR: {r, c} = {x[7], x};
      UN_ROL: {c, r} = {x, c_in};
      UN_ROR: {r, c} = {c_in, x};
      default: r = x;
    endcase
    if (u == UN_INC) v = (x == 8'h7F);
    else if (u == UN_DEC || u == UN_NEG) v = (x == 8'h80);
    else if (u inside {UN_LSL, UN_LSR, UN_ASR, UN_ROL, UN_ROR}) v = r[7] ^ c;
    return {v, c, r};
  endfunction : crf_unary

  function automatic logic crf_branch_ok(input crf_cond_t k, input logic [7:0] f);
    logic nv;
    nv = f[FLAG_N] ^ f[FLAG_V];
    unique case (k)
      CND_ALWAYS: return 1'b1;
      CND_EQ: return f[FLAG_Z];
      CND_NE: return !f[FLAG_Z];
      CND_CC: return !f[FLAG_C];
      CND_CS: return f[FLAG_C];
      CND_GREATER: return !f[FLAG_Z] && !nv; // [RULE13]
      CND_GREATER_EQUAL: return !nv; // [RULE13]
      CND_LESS_EQUAL: return f[FLAG_Z] || nv; // [RULE13]
      CND_LESS: return nv; // [RULE13]
      default: return 1'b0;
    endcase
  endfunction : crf_branch_ok

  // ----------------------------------------------------------------
  // datapath terms
  // ----------------------------------------------------------------
  logic cin;
  logic [8:0] add9;
  logic [4:0] add5;
  logic [8:0] sub9;
  logic [9:0] un_out;
  logic adj_lo;
  logic adj_hi;
  logic [7:0] adj_res;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  assign cin = op.with_carry & st_reg.flags[FLAG_C];
  assign add9 = {1'b0, st_reg.acc} + {1'b0, op.data8} + {8'h00, cin};
  assign add5 = {1'b0, st_reg.acc[3:0]} + {1'b0, op.data8[3:0]} + {4'h0, cin};
  assign sub9 = {1'b0, st_reg.acc} - {1'b0, op.data8} - {8'h00, cin};
  assign un_out = crf_unary(op.unop, st_reg.ix_l, st_reg.flags[FLAG_C]);
  // correction chosen from both flags and the digits themselves
  assign adj_lo = st_reg.flags[FLAG_H] || (st_reg.acc[3:0] > 4'h9); // [RULE15]
  assign adj_hi = st_reg.flags[FLAG_C] || (st_reg.acc > 8'h99); // [RULE15]
  assign adj_res = st_reg.acc + {1'b0, adj_hi, adj_hi, 2'b00, adj_lo, adj_lo, 1'b0}; // [RULE15]

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (axi_req.araddr)
      OFF_ACC: rd_word = {24'h000000, st_reg.acc};
      OFF_INDEX: rd_word = {16'h0000, st_reg.ix_h, st_reg.ix_l};
      OFF_STACK: rd_word = {16'h0000, st_reg.sp};
      OFF_PC: rd_word = {16'h0000, st_reg.pc};
      OFF_FLAGS: rd_word = {24'h000000, st_reg.flags};
      OFF_STATUS: rd_word = {30'h00000000, st_reg.inhibit, st_reg.run};
      default: rd_hit = 1'b0;
    endcase
  end

  assign wr_hit = (st_reg.awaddr == OFF_ACC) || (st_reg.awaddr == OFF_INDEX) ||
                  (st_reg.awaddr == OFF_STACK) || (st_reg.awaddr == OFF_PC) ||
                  (st_reg.awaddr == OFF_FLAGS) || (st_reg.awaddr == OFF_STATUS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    st_next = st_reg;
    st_next.irq_take = 1'b0;

    // reset vector fetch, two bytes high first
    unique case (st_reg.phase)
      PH_VEC_HI: begin
        st_next.vec_hi = vec_data;
        st_next.vec_addr = VEC_LO_ADDR;
        st_next.phase = PH_VEC_GAP;
      end
      PH_VEC_GAP: st_next.phase = PH_VEC_LO;
      PH_VEC_LO: begin
        st_next.pc = {st_reg.vec_hi, vec_data}; // [RULE5]
        st_next.vec_rd = 1'b0;
        st_next.phase = PH_RUN;
        st_next.run = 1'b1;
      end
      PH_RUN: st_next.run = 1'b1;
    endcase

    // ----------------------------------------------------------------
    // operations, ignored until the vector is in
    // ----------------------------------------------------------------
    if (st_reg.run) begin
      unique case (op.kind)
        OP_NONE: st_next.pc = st_reg.pc;
        OP_FETCH: st_next.pc = st_reg.pc + 16'h0001; // [RULE6]
        OP_JUMP: st_next.pc = op.data16; // [RULE6]
        OP_BRANCH: if (crf_branch_ok(op.cond, st_reg.flags)) begin
          st_next.pc = st_reg.pc + {{8{op.data8[7]}}, op.data8}; // [RULE6]
        end
        OP_LOAD_A, OP_LOAD_X, OP_STORE_A: begin
          m[7:0] = (op.kind == OP_STORE_A) ? st_reg.acc : op.data8;
          if (op.kind == OP_LOAD_A) st_next.acc = m[7:0];
          if (op.kind == OP_LOAD_X) st_next.ix_l = m[7:0]; // [RULE7]
          st_next.flags[FLAG_N] = m[7]; // [RULE18]
          st_next.flags[FLAG_Z] = (m[7:0] == 8'h00); // [RULE19]
          st_next.flags[FLAG_V] = 1'b0;
        end
        OP_LOAD_HX, OP_STORE_HX: begin
          m[15:0] = (op.kind == OP_STORE_HX) ? {st_reg.ix_h, st_reg.ix_l} : op.data16;
          st_next.ix_h = m[15:8];
          st_next.ix_l = m[7:0];
          st_next.flags[FLAG_N] = m[15]; // [RULE18]
          st_next.flags[FLAG_Z] = (m[15:0] == 16'h0000); // [RULE19]
          st_next.flags[FLAG_V] = 1'b0;
        end
        OP_ADD: begin
          st_next.acc = add9[7:0];
          st_next.flags[FLAG_C] = add9[8]; // [RULE20]
          st_next.flags[FLAG_H] = add5[4]; // [RULE14]
          st_next.flags[FLAG_V] = (st_reg.acc[7] == op.data8[7]) &&
                                  (add9[7] != st_reg.acc[7]); // [RULE13]
          st_next.flags[FLAG_N] = add9[7]; // [RULE18]
          st_next.flags[FLAG_Z] = (add9[7:0] == 8'h00); // [RULE19]
        end
        OP_SUB: begin
          st_next.acc = sub9[7:0];
          st_next.flags[FLAG_C] = sub9[8]; // [RULE20]
          st_next.flags[FLAG_V] = (st_reg.acc[7] != op.data8[7]) &&
                                  (sub9[7] != st_reg.acc[7]); // [RULE13]
          st_next.flags[FLAG_N] = sub9[7]; // [RULE18]
          st_next.flags[FLAG_Z] = (sub9[7:0] == 8'h00); // [RULE19]
        end
        OP_DECIMAL_ADJUST: begin
          st_next.acc = adj_res; // [RULE15]
          st_next.flags[FLAG_C] = st_reg.flags[FLAG_C] | adj_hi; // [RULE15]
          st_next.flags[FLAG_N] = adj_res[7]; // [RULE18]
          st_next.flags[FLAG_Z] = (adj_res == 8'h00); // [RULE19]
        end
        OP_X_UNARY: begin
          st_next.ix_l = un_out[7:0]; // [RULE8]
          st_next.flags[FLAG_C] = un_out[8]; // [RULE20]
          st_next.flags[FLAG_V] = un_out[9]; // [RULE13]
          st_next.flags[FLAG_N] = un_out[7]; // [RULE18]
          st_next.flags[FLAG_Z] = (un_out[7:0] == 8'h00); // [RULE19]
        end
        OP_BIT_TEST: st_next.flags[FLAG_C] = op.data8[op.bitsel]; // [RULE20]
        OP_ADD_TO_STACK_IMMEDIATE: begin
          st_next.sp = st_reg.sp + {{8{op.data8[7]}}, op.data8}; // [RULE10]
        end
        OP_RESET_STACK_LOW: st_next.sp = {st_reg.sp[15:8], STACK_LOW_FILL}; // [RULE11]
        // pointer always names the free slot: push writes then moves down
        OP_PUSH: st_next.sp = st_reg.sp - 16'h0001; // [RULE9]
        OP_PULL: st_next.sp = st_reg.sp + 16'h0001; // [RULE9]
        OP_CLEAR_MASK_INSTR: begin
          st_next.flags[FLAG_I] = 1'b0;
          st_next.inhibit = 1'b1; // [RULE17]
        end
        OP_SEI: st_next.flags[FLAG_I] = 1'b1;
        OP_TAP: begin
          st_next.flags = st_reg.acc;
          st_next.inhibit = !st_reg.acc[FLAG_I]; // [RULE17]
        end
        // issued by the sequencer once registers are stacked
        OP_INT_ENTRY: st_next.flags[FLAG_I] = 1'b1; // [RULE16]
        OP_HX_INC: {st_next.ix_h, st_next.ix_l} = {st_reg.ix_h, st_reg.ix_l} + 16'h0001; // [RULE7]
        default: st_next.pc = st_reg.pc;
      endcase

      // interrupt recognition at the boundary
      if (insn_boundary) begin
        st_next.irq_take = irq_request && !st_reg.flags[FLAG_I] && !st_reg.inhibit; // [RULE16]
        if (op.kind != OP_CLEAR_MASK_INSTR && op.kind != OP_TAP) begin
          st_next.inhibit = 1'b0; // [RULE17]
        end
      end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave; a bus write overrides an op in the same cycle
    // ----------------------------------------------------------------
    if (st_reg.rsp.awready && axi_req.awvalid) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = axi_req.awaddr;
    end
    if (st_reg.rsp.wready && axi_req.wvalid) begin
      st_next.w_held = 1'b1;
      st_next.wdata = axi_req.wdata;
      st_next.wstrb = axi_req.wstrb;
    end
    if (st_reg.rsp.bvalid && axi_req.bready) st_next.rsp.bvalid = 1'b0;
    if (st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      unique case (st_reg.awaddr)
        OFF_ACC: begin
          m = crf_merge({24'h000000, st_reg.acc}, st_reg.wdata, st_reg.wstrb);
          st_next.acc = m[7:0];
        end
        OFF_INDEX: begin
          m = crf_merge({16'h0000, st_reg.ix_h, st_reg.ix_l}, st_reg.wdata, st_reg.wstrb);
          st_next.ix_h = m[15:8];
          st_next.ix_l = m[7:0];
        end
        OFF_STACK: begin
          m = crf_merge({16'h0000, st_reg.sp}, st_reg.wdata, st_reg.wstrb);
          st_next.sp = m[15:0];
        end
        OFF_PC: begin
          m = crf_merge({16'h0000, st_reg.pc}, st_reg.wdata, st_reg.wstrb);
          st_next.pc = m[15:0];
        end
        OFF_FLAGS: begin
          m = crf_merge({24'h000000, st_reg.flags}, st_reg.wdata, st_reg.wstrb);
          st_next.flags = m[7:0];
        end
        default: m = 32'h0000_0000;
      endcase
    end
    st_next.rsp.awready = !st_next.aw_held;
    st_next.rsp.wready = !st_next.w_held;

    if (st_reg.rsp.rvalid && axi_req.rready) st_next.rsp.rvalid = 1'b0;
    if (st_reg.rsp.arready && axi_req.arvalid) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata = rd_word;
      st_next.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    st_next.rsp.arready = !st_next.rsp.rvalid;

    st_next.flags = st_next.flags | FLAGS_ONES; // [RULE12]

    // ----------------------------------------------------------------
    // synchronous reset; accumulator and index low keep their value
    // ----------------------------------------------------------------
    if (!aresetn) begin
      st_next.acc = st_reg.acc; // [RULE1]
      st_next.ix_l = st_reg.ix_l; // [RULE3]
      st_next.ix_h = INDEX_HIGH_RST; // [RULE2]
      st_next.sp = STACK_RST; // [RULE4]
      st_next.pc = 16'h0000;
      st_next.flags = FLAGS_RST; // [RULE21]
      st_next.inhibit = 1'b0;
      st_next.irq_take = 1'b0;
      st_next.phase = PH_VEC_HI;
      st_next.run = 1'b0;
      st_next.vec_hi = 8'h00;
      st_next.vec_addr = VEC_HI_ADDR; // [RULE5]
      st_next.vec_rd = 1'b1;
      st_next.aw_held = 1'b0;
      st_next.awaddr = '0;
      st_next.w_held = 1'b0;
      st_next.wdata = 32'h0000_0000;
      st_next.wstrb = 4'h0;
      st_next.rsp = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign vec_rd = st_reg.vec_rd;
  assign vec_addr = st_reg.vec_addr;
  assign cpu_ready = st_reg.run;
  assign accumulator = st_reg.acc;
  assign index_pair = {st_reg.ix_h, st_reg.ix_l}; // [RULE7]
  assign stack_pointer = st_reg.sp;
  assign program_counter = st_reg.pc;
  assign condition_flags = st_reg.flags;
  assign irq_take = st_reg.irq_take;
  assign axi_rsp = st_reg.rsp;
endmodule : crf_regs

// >>> bench/crf_regs_chk.sv
// port checker for the cpu register file
// assumes it is bound onto crf_regs, one clock, sync active-low reset
module crf_regs_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // operation side
  input wire crf_pkg::crf_op_t op,
  input wire logic insn_boundary,
  input wire logic irq_request,
  // register views
  input wire logic cpu_ready,
  input wire logic [15:0] index_pair,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] condition_flags,
  input wire logic irq_take
);
  import crf_pkg::*;
  // ----
  // inhibit tracker and properties
  // ----
  // armed by a mask clear, dropped by the boundary that follows
  logic inhibit_reg;
  logic inhibit_next;
  always_comb begin
    inhibit_next = (cpu_ready && op.kind == OP_CLEAR_MASK_INSTR) ||
                   (inhibit_reg && !insn_boundary);
  end
  always_ff @(posedge aclk) begin
    inhibit_reg <= aresetn && inhibit_next;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_flag_ones: assert property (condition_flags[6:5] == 2'b11)
    else $error("flag bits 6 and 5 not one");
  a_rst_index: assert property ($rose(aresetn) |-> index_pair[15:8] == 8'h00)
    else $error("index high not cleared by reset");
  a_rst_stack: assert property ($rose(aresetn) |-> stack_pointer == 16'h00FF)
    else $error("stack pointer reset value wrong");
  a_rst_mask: assert property ($rose(aresetn) |-> condition_flags[FLAG_I])
    else $error("mask not set by reset");
  a_fetch_step: assert property (cpu_ready && op.kind == OP_FETCH |=>
    program_counter == $past(program_counter) + 16'h1) else $error("fetch did not step pc");
  a_stack_add: assert property (cpu_ready && op.kind == OP_ADD_TO_STACK_IMMEDIATE |=>
    stack_pointer == $past(stack_pointer) + {{8{$past(op.data8[7])}}, $past(op.data8)})
    else $error("stack add not sign extended");
  a_stack_low: assert property (cpu_ready && op.kind == OP_RESET_STACK_LOW |=>
    stack_pointer == {$past(stack_pointer[15:8]), 8'hFF}) else $error("stack reset wrong");
  a_entry_mask: assert property (cpu_ready && op.kind == OP_INT_ENTRY |=>
    condition_flags[FLAG_I]) else $error("mask not set on entry");
  a_load_nz: assert property (cpu_ready && op.kind == OP_LOAD_A |=>
    condition_flags[FLAG_N] == $past(op.data8[7])
    && condition_flags[FLAG_Z] == ($past(op.data8) == 8'h00)) else $error("load flags wrong");
  a_take_cause: assert property (irq_take |-> $past(insn_boundary) && $past(irq_request)
    && !$past(condition_flags[FLAG_I]) && !$past(inhibit_reg)) else $error("stray take");
  a_cli_block: assert property (insn_boundary && inhibit_reg |=> !irq_take)
    else $error("take right after mask clear");
  c_take: cover property (irq_take);
  c_decimal: cover property (cpu_ready && op.kind == OP_DECIMAL_ADJUST);
  c_stack_low: cover property (cpu_ready && op.kind == OP_RESET_STACK_LOW);
endmodule : crf_regs_chk

bind crf_regs crf_regs_chk chk_u (.aclk(aclk), .aresetn(aresetn), .op(op),
  .insn_boundary(insn_boundary), .irq_request(irq_request), .cpu_ready(cpu_ready),
  .index_pair(index_pair), .stack_pointer(stack_pointer), .program_counter(program_counter),
  .condition_flags(condition_flags), .irq_take(irq_take));

// >>> bench/crf_regs_tb.sv
// self-checking bench for the cpu register file
// assumes the crf_regs_chk checker is bound in; vector memory modelled here
module crf_regs_tb;
  import crf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // stimulus, model and tasks
  // ----
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  crf_op_t op = '0;
  logic insn_boundary = 1'b0;
  logic irq_request = 1'b0;
  logic [7:0] vec_data = 8'h00;
  crf_axi_req_t axi_req = '0;
  crf_axi_rsp_t axi_rsp;
  logic vec_rd, cpu_ready, irq_take;
  logic [15:0] vec_addr, index_pair, stack_pointer, program_counter;
  logic [7:0] accumulator, condition_flags;
  int num_errors = 0;
  int tests_run = 0;
  // a, b, result, flag mask, flags
  logic [39:0] alu_tab [5] = '{40'h08_08_10_97_10, 40'h7F_01_80_97_94,
    40'hFF_01_00_97_13, 40'h00_01_FF_87_05, 40'h80_01_7F_87_80};
  // rotates take the carry left by the op before them: ASR before ROL, ROL before ROR
  crf_unop_t un_tab [10] = '{UN_CLR, UN_INC, UN_DEC, UN_COM, UN_NEG, UN_LSL, UN_LSR, UN_ASR,
    UN_ROL, UN_ROR};
  logic [7:0] un_exp [10] = '{8'h00, 8'h06, 8'h04, 8'hFA, 8'hFB, 8'h0A, 8'h02, 8'h02, 8'h0B,
    8'h02};
  always #10 aclk = ~aclk;
  // vector memory answers a cycle after the address
  always @(posedge aclk) vec_data <= (vec_addr == VEC_HI_ADDR) ? 8'hC3 : 8'h21;
  crf_regs dut_u (.aclk(aclk), .aresetn(aresetn), .op(op), .insn_boundary(insn_boundary),
    .irq_request(irq_request), .vec_data(vec_data), .vec_rd(vec_rd), .vec_addr(vec_addr),
    .cpu_ready(cpu_ready), .accumulator(accumulator), .index_pair(index_pair),
    .stack_pointer(stack_pointer), .program_counter(program_counter),
    .condition_flags(condition_flags), .irq_take(irq_take), .axi_req(axi_req),
    .axi_rsp(axi_rsp));
  task final_report;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task fail_to(input string nm);
    $display("ERROR %s expected handshake seen timeout", nm);
    num_errors++;
    final_report();
  endtask : fail_to
  task automatic do_reset;
    int n;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (n = 0; n < 20 && cpu_ready !== 1'b1; n++) @(posedge aclk);
    if (cpu_ready !== 1'b1) fail_to("cpu_ready");
  endtask : do_reset
  task automatic do_op(input crf_opk_t k, input crf_unop_t u, input logic [15:0] d);
    @(posedge aclk);
    op <= '{k, u, CND_ALWAYS, 1'b0, 3'h0, d[7:0], d};
    @(posedge aclk);
    op.kind <= OP_NONE;
    #1;
  endtask : do_op
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) break;
    end
    axi_req.bready <= 1'b0;
    if (n == 50) fail_to("bvalid");
    chk("bresp", 32'(RESP_OKAY), 32'(axi_rsp.bresp));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1) break;
    end
    if (n == 50) fail_to("rvalid");
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axi_rd
  task automatic boundary(input logic e);
    @(posedge aclk);
    insn_boundary <= 1'b1;
    @(posedge aclk);
    insn_boundary <= 1'b0;
    #1 chk("irq_take", 32'(e), 32'(irq_take));
  endtask : boundary
  initial begin
    int i;
    logic [31:0] rd;
    logic [1:0] rr;
    do_reset();
    chk("pc_vector", 32'h0000C321, 32'(program_counter));
    chk("vec_rd", 32'h0, 32'(vec_rd));
    axi_wr(OFF_ACC, 32'h0000005A);
    axi_wr(OFF_INDEX, 32'h00001234);
    axi_wr(OFF_FLAGS, 32'h00000000);
    chk("flags_ones", 32'h60, 32'(condition_flags));
    do_reset();
    chk("acc_keep", 32'h5A, 32'(accumulator));
    chk("index_rst", 32'h0034, 32'(index_pair));
    chk("stack_rst", 32'h00FF, 32'(stack_pointer));
    chk("flags_rst", 32'h68, 32'(condition_flags));
    do_op(OP_FETCH, UN_CLR, 16'h0000);
    chk("pc_fetch", 32'hC322, 32'(program_counter));
    do_op(OP_JUMP, UN_CLR, 16'h8000);
    chk("pc_jump", 32'h8000, 32'(program_counter));
    for (i = 0; i < 5; i++) begin
      do_op(OP_LOAD_A, UN_CLR, {8'h00, alu_tab[i][39:32]});
      do_op(i < 3 ? OP_ADD : OP_SUB, UN_CLR, {8'h00, alu_tab[i][31:24]});
      chk("alu_acc", 32'(alu_tab[i][23:16]), 32'(accumulator));
      chk("alu_flags", 32'(alu_tab[i][7:0]), 32'(condition_flags & alu_tab[i][15:8]));
    end
    do_op(OP_LOAD_A, UN_CLR, 16'h0019);
    do_op(OP_ADD, UN_CLR, 16'h0028);
    do_op(OP_DECIMAL_ADJUST, UN_CLR, 16'h0000);
    chk("adjust_acc", 32'h47, 32'(accumulator));
    axi_wr(OFF_STACK, 32'h00001230);
    do_op(OP_ADD_TO_STACK_IMMEDIATE, UN_CLR, 16'h00FE);
    chk("stack_add", 32'h122E, 32'(stack_pointer));
    do_op(OP_RESET_STACK_LOW, UN_CLR, 16'h0000);
    chk("stack_low", 32'h12FF, 32'(stack_pointer));
    do_op(OP_ADD_TO_STACK_IMMEDIATE, UN_CLR, 16'h0001);
    chk("stack_carry", 32'h1300, 32'(stack_pointer));
    do_op(OP_PUSH, UN_CLR, 16'h0000);
    chk("stack_push", 32'h12FF, 32'(stack_pointer));
    do_op(OP_PULL, UN_CLR, 16'h0000);
    chk("stack_pull", 32'h1300, 32'(stack_pointer));
    for (i = 0; i < 10; i++) begin
      axi_wr(OFF_INDEX, 32'h00001205);
      do_op(OP_X_UNARY, un_tab[i], 16'h0000);
      chk("index_unary", {16'h0, 8'h12, un_exp[i]}, 32'(index_pair));
    end
    @(posedge aclk);
    irq_request <= 1'b1;
    boundary(1'b0);
    do_op(OP_CLEAR_MASK_INSTR, UN_CLR, 16'h0000);
    boundary(1'b0);
    boundary(1'b1);
    do_op(OP_INT_ENTRY, UN_CLR, 16'h0000);
    chk("mask_entry", 32'h1, 32'(condition_flags[FLAG_I]));
    boundary(1'b0);
    axi_rd(OFF_STACK, rd, rr);
    chk("rresp_ok", 32'(RESP_OKAY), 32'(rr));
    chk("rd_stack", 32'h1300, rd);
    axi_rd(8'h18, rd, rr);
    chk("rresp", 32'(RESP_SLVERR), 32'(rr));
    chk("rdata", 32'h0, rd);
    final_report();
  end
endmodule : crf_regs_tb
